// [design/slt_flash_end.sv]
/*
 * device end: answers a read of the band latency table over the serial link,
 * holding the data back by exactly the mode plus latency cycles of the band.
 * assumes sck runs only while cs_n is low and that band_i is stable before a
 * frame starts; all state is cleared by cs_n high.
 */
// Operation
// - first band limit 50 MHz, byte 32h
// - code 11b cycle counts per read kind
// - code 00b belongs to 80 MHz band
// - code 00b cycle counts per read kind
// - FFh marks unsupported; normal read lowest only
// - code 01b belongs to 90 MHz band
// - code 01b cycle counts per read kind
// - 104 MHz band, code 10b cycle counts
// - 133 MHz band, fast read only
// - row starts with limit byte, code byte
// - pairs in fixed read command order
`timescale 1ns/100ps

module slt_flash_end (
    slt_link_if.dev link,
    input wire logic [2:0] band_i,
    output logic [1:0] latency_code_o,
    output logic reject_o
);

    ////////////////////////////////////////////////////////////////////////////
    // types and state

    // frame phases of the device
    typedef enum logic [2:0] {
        st_cmd,
        st_wait,
        st_data,
        st_end,
        st_reject
    } slt_dev_state_t;

    slt_dev_state_t state_reg; // current phase
    slt_dev_state_t state_next;
    logic [2:0] band_s1_reg; // first sync stage, read by stage two only
    logic [2:0] band_s2_reg; // band in the link domain
    logic [3:0] bit_cnt_reg; // command or data bit count
    logic [3:0] bit_cnt_next;
    logic [8:0] cmd_reg; // command bits gathered so far
    logic [8:0] cmd_next;
    logic [4:0] wait_cnt_reg; // remaining mode plus latency cycles
    logic [4:0] wait_cnt_next;
    logic [7:0] data_reg; // byte being sent, msb first
    logic [7:0] data_next;
    logic miso_reg; // bit on the data line
    logic miso_next;
    logic oe_reg; // data line driven
    logic oe_next;
    logic [1:0] code_reg; // latency code of the band in use
    logic [1:0] code_next;
    logic reject_reg; // frame refused
    logic reject_next;

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    // whole command once the tenth bit arrives
    wire logic [9:0] cmd_full = {cmd_reg, link.mosi};
    wire logic [2:0] cmd_kind = cmd_full[9:7];
    wire logic [6:0] cmd_addr = cmd_full[6:0];
    wire logic cmd_last = (bit_cnt_reg == 4'(`SLT_CMD_BITS - 1));

    // unsupported pair, illegal kind or band beyond the table
    wire logic cmd_unsup = slt_pkg::slt_unsup(band_s2_reg, cmd_kind);
    // cycles to hold the data back for this band and kind
    wire logic [4:0] cmd_wait = slt_pkg::slt_wait(band_s2_reg, cmd_kind);

    // table position of the addressed byte
    wire logic [2:0] addr_row = 3'(int'(cmd_addr) / `SLT_ROW_LEN);
    wire logic [3:0] addr_col = 4'(int'(cmd_addr) % `SLT_ROW_LEN);
    wire logic addr_ok = (int'(cmd_addr) < `SLT_TABLE_BYTES);
    // rows give limit, code, then pairs in command order; outside reads zero
    wire logic [7:0] addr_byte = addr_ok ? slt_pkg::slt_cell(addr_row, addr_col) : 8'h00;

    // code byte of the band row, low two bits carry the code
    wire logic [7:0] band_code_byte = slt_pkg::slt_cell(band_s2_reg, 4'(`SLT_COL_CODE));

    // limit byte of the band row; the lowest row holds the 50 MHz limit
    wire logic [7:0] band_freq_byte = slt_pkg::slt_cell(band_s2_reg, 4'(`SLT_COL_FREQ));

    ////////////////////////////////////////////////////////////////////////////
    // next state

    // frame sequencer, one step per rising sck
    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        cmd_next = cmd_reg;
        wait_cnt_next = wait_cnt_reg;
        data_next = data_reg;
        miso_next = miso_reg;
        oe_next = oe_reg;
        code_next = code_reg;
        reject_next = reject_reg;
        unique case (state_reg)
            // gather kind and address, msb first
            st_cmd: begin
                cmd_next = cmd_full[8:0];
                bit_cnt_next = bit_cnt_reg + 4'h1;
                if (cmd_last) begin
                    code_next = band_code_byte[1:0];
                    bit_cnt_next = 4'h0;
                    if (cmd_unsup || band_freq_byte == `SLT_UNSUP) begin
                        // refused: line stays undriven for the rest of the frame
                        reject_next = 1'b1;
                        state_next = st_reject;
                    end else if (cmd_wait == 5'h0) begin
                        // no dummy cycles: first bit follows the address
                        miso_next = addr_byte[7];
                        oe_next = 1'b1;
                        data_next = {addr_byte[6:0], 1'b0};
                        state_next = st_data;
                    end else begin
                        data_next = addr_byte;
                        wait_cnt_next = cmd_wait;
                        state_next = st_wait;
                    end
                end
            end
            // mode and latency cycles; the line is not driven meanwhile
            st_wait: begin
                wait_cnt_next = wait_cnt_reg - 5'h1;
                if (wait_cnt_reg == 5'h1) begin
                    miso_next = data_reg[7];
                    oe_next = 1'b1;
                    data_next = {data_reg[6:0], 1'b0};
                    state_next = st_data;
                end
            end
            // remaining seven data bits
            st_data: begin
                miso_next = data_reg[7];
                data_next = {data_reg[6:0], 1'b0};
                bit_cnt_next = bit_cnt_reg + 4'h1;
                if (bit_cnt_reg == 4'(`SLT_DATA_BITS - 2)) begin
                    state_next = st_end;
                end
            end
            // last bit held until the frame closes
            st_end: begin
                state_next = st_end;
            end
            st_reject: begin
                state_next = st_reject;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // band crosses into the link domain through two stages; cleared by the
    // frame signal since sck cannot be relied on outside a frame
    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            band_s1_reg <= 3'h0;
            band_s2_reg <= 3'h0;
        end else begin
            band_s1_reg <= band_i;
            band_s2_reg <= band_s1_reg;
        end
    end

    // frame state; cs_n high ends any frame at once
    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            state_reg <= st_cmd;
            bit_cnt_reg <= 4'h0;
            cmd_reg <= 9'h000;
            wait_cnt_reg <= 5'h00;
            data_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            cmd_reg <= cmd_next;
            wait_cnt_reg <= wait_cnt_next;
            data_reg <= data_next;
        end
    end

    // outputs; the code stays visible only for the frame that used it
    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            miso_reg <= 1'b0;
            oe_reg <= 1'b0;
            code_reg <= 2'h0;
            reject_reg <= 1'b0;
        end else begin
            miso_reg <= miso_next;
            oe_reg <= oe_next;
            code_reg <= code_next;
            reject_reg <= reject_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port drive

    assign link.miso = miso_reg;
    assign link.miso_oe = oe_reg;
    assign latency_code_o = code_reg;
    assign reject_o = reject_reg;

endmodule

// [design/slt_map.svh]
/*
 * constants of the sdr read latency table: band rows, timing, link framing.
 * assumes it is included by bare name from the package only.
 */
`ifndef SLT_MAP_SVH
`define SLT_MAP_SVH

// one band row: freq limit, latency code, then mode/latency pairs in the order
// normal, fast, dual out, quad out, dual io, quad io
`define SLT_ROW_LEN 14
`define SLT_ROWS 5
`define SLT_COL_FREQ 0
`define SLT_COL_CODE 1
`define SLT_COL_PAIR0 2
`define SLT_UNSUP 8'hff
`define SLT_ROW0 112'h32_03_00_00_00_00_00_00_00_00_00_04_02_01
`define SLT_ROW1 112'h50_00_ff_ff_00_08_00_08_00_08_00_04_02_04
`define SLT_ROW2 112'h5a_01_ff_ff_00_08_00_08_00_08_00_05_02_04
`define SLT_ROW3 112'h68_02_ff_ff_00_08_00_08_00_08_00_06_02_05
`define SLT_ROW4 112'h85_02_ff_ff_00_08_ff_ff_ff_ff_ff_ff_ff_ff
// table bytes addressable over the link
`define SLT_TABLE_BYTES 70
// link framing: 3 kind bits then 7 address bits, then 8 data bits
`define SLT_CMD_BITS 10
`define SLT_DATA_BITS 8
// timing
`define SLT_REF_PERIOD_NS 5
`define SLT_SCK_PERIOD_NS 125
`define SLT_SCK_HALF_CYC (`SLT_SCK_PERIOD_NS / (2 * `SLT_REF_PERIOD_NS))

`endif

// [design/slt_pkg.sv]
/*
 * types and table lookups shared by both ends of the latency link.
 * assumes slt_map.svh is on the include path.
 */
`include "slt_map.svh"

package slt_pkg;

    // read command kinds, in table column order
    typedef enum logic [2:0] {
        slt_rd_normal,
        slt_rd_fast,
        slt_rd_dual_out,
        slt_rd_quad_out,
        slt_rd_dual_io,
        slt_rd_quad_io
    } slt_kind_t;

    typedef logic [7:0] slt_byte_t;

    // one whole band row; rows above the last read as unsupported
    function automatic logic [111:0] slt_row_bits(input logic [2:0] row);
        unique case (row)
            3'h0: return `SLT_ROW0;
            3'h1: return `SLT_ROW1;
            3'h2: return `SLT_ROW2;
            3'h3: return `SLT_ROW3;
            3'h4: return `SLT_ROW4;
            default: return {14{`SLT_UNSUP}};
        endcase
    endfunction

    // byte at a column of a row, column 0 first
    function automatic slt_byte_t slt_cell(input logic [2:0] row, input logic [3:0] col);
        logic [111:0] bits;
        bits = slt_row_bits(row);
        return bits[8 * (`SLT_ROW_LEN - 1 - int'(col)) +: 8];
    endfunction

    function automatic slt_byte_t slt_mode(input logic [2:0] row, input logic [2:0] kind);
        return slt_cell(row, 4'(`SLT_COL_PAIR0 + 2 * int'(kind)));
    endfunction

    function automatic slt_byte_t slt_lat(input logic [2:0] row, input logic [2:0] kind);
        return slt_cell(row, 4'(`SLT_COL_PAIR0 + 1 + 2 * int'(kind)));
    endfunction

    // unsupported when the pair carries the marker or the kind is illegal
    function automatic logic slt_unsup(input logic [2:0] row, input logic [2:0] kind);
        return (kind > 3'(slt_rd_quad_io)) || (row >= 3'(`SLT_ROWS)) ||
               (slt_mode(row, kind) == `SLT_UNSUP) || (slt_lat(row, kind) == `SLT_UNSUP);
    endfunction

    // mode plus latency cycles between address and first data
    function automatic logic [4:0] slt_wait(input logic [2:0] row, input logic [2:0] kind);
        return 5'(slt_mode(row, kind)) + 5'(slt_lat(row, kind));
    endfunction

    // lowest row whose limit is at or above the clock; 5 when none is
    function automatic logic [2:0] slt_band(input logic [7:0] mhz);
        logic [2:0] row;
        row = 3'(`SLT_ROWS);
        for (int r = `SLT_ROWS - 1; r >= 0; r--) begin
            if (slt_cell(3'(r), 4'(`SLT_COL_FREQ)) >= mhz) begin
                row = 3'(r);
            end
        end
        return row;
    endfunction

endpackage

// [design/slt_link_if.sv]
/*
 * serial read link between the latency table holder and its host.
 * assumes the host makes sck and cs_n; sck stands still while cs_n is high.
 */
`timescale 1ns/100ps

interface slt_link_if;
    logic sck;     // serial clock, host made
    logic cs_n;    // frame select, low during a frame
    logic mosi;    // command bits, host to device
    logic miso;    // data bits, device to host
    logic miso_oe; // high while the device drives miso

    modport dev (input sck, input cs_n, input mosi, output miso, output miso_oe);
    modport host (output sck, output cs_n, output mosi, input miso, input miso_oe);
endinterface

// [design/slt_host_end.sv]
/*
 * host end: picks the band for its clock rate, makes sck by a divider,
 * sends kind and address, skips the band's mode and latency cycles and
 * returns the byte. assumes HALF_DIV of at least 3 so the synced data line
 * settles well inside one sck period.
 */
`timescale 1ns/100ps

module slt_host_end #(
    parameter int HALF_DIV = `SLT_SCK_HALF_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    slt_link_if.host link,
    input wire logic start_i,
    input wire logic [2:0] kind_i,
    input wire logic [6:0] addr_i,
    input wire logic [7:0] freq_mhz_i,
    output logic busy_o,
    output logic done_o,
    output logic unsup_o,
    output logic [1:0] code_o,
    output logic [7:0] data_o
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef enum logic [1:0] {
        st_idle,
        st_run,
        st_fin
    } slt_host_state_t;

    slt_host_state_t state_reg;
    logic [7:0] div_reg; // ref cycles left in this sck half
    logic sck_reg; // made serial clock
    logic cs_n_reg; // frame select
    logic [9:0] tx_reg; // command bits, msb on the line
    logic [4:0] rise_reg; // sck rises made in the frame
    logic [4:0] wait_reg; // band cycles for this read
    logic [7:0] rx_reg; // gathered data bits
    logic miso_s1_reg; // first sync stage, read by stage two only
    logic miso_s2_reg; // data line in the ref domain
    logic done_reg;
    logic unsup_reg;
    logic [1:0] code_reg;
    logic [7:0] data_reg;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // lowest band at or above the clock rate
    wire logic [2:0] pick_band = slt_pkg::slt_band(freq_mhz_i);
    wire logic pick_unsup = slt_pkg::slt_unsup(pick_band, kind_i);
    wire logic [4:0] pick_wait = slt_pkg::slt_wait(pick_band, kind_i);
    wire logic [7:0] pick_code = slt_pkg::slt_cell(pick_band, 4'(`SLT_COL_CODE));
    wire logic half_end = (div_reg == 8'h00);
    // first rise after which a data bit stands on the line
    wire logic [4:0] first_data = 5'(`SLT_CMD_BITS) + wait_reg;
    wire logic [4:0] last_rise = first_data + 5'(`SLT_DATA_BITS - 1);
    wire logic sample = (rise_reg >= first_data);

    ////////////////////////////////////////////////////////////////////////////
    // data line sync

    // two stages before any logic looks at the device's line
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            miso_s1_reg <= 1'b0;
            miso_s2_reg <= 1'b0;
        end else begin
            miso_s1_reg <= link.miso;
            miso_s2_reg <= miso_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame engine

    // samples are taken just before the next rise, a full period after the
    // device changed the line, which costs one period but needs no fall edge
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_reg <= st_idle;
            div_reg <= 8'h00;
            sck_reg <= 1'b0;
            cs_n_reg <= 1'b1;
            tx_reg <= 10'h000;
            rise_reg <= 5'h00;
            wait_reg <= 5'h00;
            rx_reg <= 8'h00;
            done_reg <= 1'b0;
            unsup_reg <= 1'b0;
            code_reg <= 2'h0;
            data_reg <= 8'h00;
        end else begin
            done_reg <= 1'b0;
            div_reg <= half_end ? 8'(HALF_DIV - 1) : div_reg - 8'h01;
            unique case (state_reg)
                st_idle: begin
                    div_reg <= 8'(HALF_DIV - 1);
                    if (start_i) begin
                        code_reg <= pick_code[1:0];
                        unsup_reg <= pick_unsup;
                        if (pick_unsup) begin
                            // never issued: done at once, no frame
                            done_reg <= 1'b1;
                        end else begin
                            cs_n_reg <= 1'b0;
                            tx_reg <= {kind_i, addr_i};
                            wait_reg <= pick_wait;
                            rise_reg <= 5'h00;
                            state_reg <= st_run;
                        end
                    end
                end
                st_run: begin
                    if (half_end && sck_reg) begin
                        // fall: next command bit onto the line
                        sck_reg <= 1'b0;
                        tx_reg <= {tx_reg[8:0], 1'b0};
                    end else if (half_end) begin
                        if (sample) begin
                            rx_reg <= {rx_reg[6:0], miso_s2_reg};
                        end
                        if (rise_reg == last_rise) begin
                            data_reg <= {rx_reg[6:0], miso_s2_reg};
                            cs_n_reg <= 1'b1;
                            state_reg <= st_fin;
                        end else begin
                            sck_reg <= 1'b1;
                            rise_reg <= rise_reg + 5'h01;
                        end
                    end
                end
                // cs_n high for one half period before the next frame
                st_fin: begin
                    if (half_end) begin
                        done_reg <= 1'b1;
                        state_reg <= st_idle;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port drive

    assign link.sck = sck_reg;
    assign link.cs_n = cs_n_reg;
    assign link.mosi = tx_reg[9];
    assign busy_o = (state_reg != st_idle);
    assign done_o = done_reg;
    assign unsup_o = unsup_reg;
    assign code_o = code_reg;
    assign data_o = data_reg;

endmodule

// [bench/slt_link_checker.sv]
/*
 * checker for the serial link between the host end and the table device end.
 * assumes it is instantiated beside the link, clocked by the host's ref clock.
 */
`timescale 1ns/100ps

module slt_link_checker #(
    parameter int HALF_DIV = 3
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    logic sck_q; // sck one ref cycle ago
    logic oe_q; // miso_oe one ref cycle ago
    logic [4:0] rise_cnt; // sck rises in this frame
    logic [4:0] oe_cnt; // rises after the first data bit
    logic [4:0] hi_cnt; // ref cycles of the current sck high phase
    wire rise_w = sck && !sck_q;

    ////////////////////////////////////////////////////////////////
    // counters restart whenever the frame select is high
    always_ff @(posedge ref_clk_i) begin
        sck_q <= sck;
        oe_q <= miso_oe;
        rise_cnt <= cs_n ? 5'h00 : rise_cnt + 5'(rise_w);
        oe_cnt <= cs_n ? 5'h00 : oe_cnt + 5'(rise_w && oe_q);
        hi_cnt <= sck ? hi_cnt + 5'h01 : 5'h00;
    end

    ////////////////////////////////////////////////////////////////
    // a frame opens with a low half before the first rise
    sequence s_lead_low;
        !sck [*2];
    endsequence
    // the data line holds between rises
    sequence s_miso_calm;
        !rise_w && miso_oe && oe_q;
    endsequence

    property p_oe_idle;
        cs_n |-> !miso_oe;
    endproperty
    property p_sck_idle;
        cs_n |-> !sck;
    endproperty
    property p_frame_start;
        $fell(cs_n) |-> s_lead_low;
    endproperty
    property p_frame_bound;
        $fell(cs_n) |-> ##[60:400] cs_n;
    endproperty
    property p_hi_phase;
        $fell(sck) |-> hi_cnt == 5'(HALF_DIV);
    endproperty
    property p_mosi_step;
        sck && sck_q |-> $stable(mosi);
    endproperty
    property p_miso_step;
        s_miso_calm |-> $stable(miso);
    endproperty
    property p_oe_hold;
        miso_oe && !cs_n |=> miso_oe || cs_n;
    endproperty
    // first data rise is rise 10 plus at most 8 wait cycles
    property p_first_data;
        $rose(miso_oe) |-> rise_cnt >= 5'h09 && rise_cnt <= 5'h11;
    endproperty
    property p_data_len;
        $rose(cs_n) && oe_q |-> oe_cnt == 5'h07;
    endproperty

    a_oe_idle: assert property (p_oe_idle) else $error("miso driven outside a frame");
    a_sck_idle: assert property (p_sck_idle) else $error("sck moves outside a frame");
    a_frame_start: assert property (p_frame_start) else $error("frame opens with sck high");
    a_frame_bound: assert property (p_frame_bound) else $error("frame length out of range");
    a_hi_phase: assert property (p_hi_phase) else $error("sck high phase wrong");
    a_mosi_step: assert property (p_mosi_step) else $error("mosi moves while sck high");
    a_miso_step: assert property (p_miso_step) else $error("miso moves between rises");
    a_oe_hold: assert property (p_oe_hold) else $error("miso released mid frame");
    a_first_data: assert property (p_first_data) else $error("first data rise out of range");
    a_data_len: assert property (p_data_len) else $error("data not eight bits");
endmodule

// [bench/sdr_read_latency_table_bench.sv]
/*
 * bench: host reads every table byte through the device end; a second
 * device end is driven bit by bit to check its wait cycles and refusals.
 * assumes the design files and package are compiled first.
 */
`timescale 1ns/100ps

module sdr_read_latency_table_bench;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic start_i = 1'b0;
    logic [2:0] kind_i = 3'h0;
    logic [6:0] addr_i = 7'h00;
    logic [7:0] freq_mhz_i = 8'h32;
    logic [2:0] band_i = 3'h0; // device band, follows the host's choice
    logic [2:0] band2_i = 3'h0; // band of the hand-driven device
    logic busy_o, done_o, unsup_o, rej_o, rej2_o;
    logic [1:0] code_o, dcode_o, dcode2_o;
    logic [7:0] data_o, got;
    int failures = 0;
    int compares = 0;
    slt_link_if link1();
    slt_link_if link2();

    slt_host_end #(.HALF_DIV(3)) slt_host_end_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(link1),
        .start_i(start_i), .kind_i(kind_i), .addr_i(addr_i), .freq_mhz_i(freq_mhz_i), .busy_o(busy_o),
        .done_o(done_o), .unsup_o(unsup_o), .code_o(code_o), .data_o(data_o));
    slt_flash_end slt_flash_end_inst (.link(link1), .band_i(band_i), .latency_code_o(dcode_o), .reject_o(rej_o));
    slt_flash_end slt_flash_end_inst2 (.link(link2), .band_i(band2_i), .latency_code_o(dcode2_o),
        .reject_o(rej2_o));
    slt_link_checker #(.HALF_DIV(3)) slt_link_checker_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .sck(link1.sck), .cs_n(link1.cs_n), .mosi(link1.mosi), .miso(link1.miso), .miso_oe(link1.miso_oe));

    // 200 MHz reference clock
    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    ////////////////////////////////////////////////////////////////
    // expected table, rows of limit, code, then mode/latency pairs
    function automatic logic [7:0] etb(input int a);
        logic [559:0] t;
        t = {112'h32_03_00_00_00_00_00_00_00_00_00_04_02_01, 112'h50_00_ff_ff_00_08_00_08_00_08_00_04_02_04,
             112'h5a_01_ff_ff_00_08_00_08_00_08_00_05_02_04, 112'h68_02_ff_ff_00_08_00_08_00_08_00_06_02_05,
             112'h85_02_ff_ff_00_08_ff_ff_ff_ff_ff_ff_ff_ff};
        return (a >= 70) ? 8'h00 : t[559 - 8 * a -: 8];
    endfunction
    // lowest band whose limit covers the rate; 5 means none
    function automatic int bandof(input int mhz);
        for (int r = 0; r < 5; r++) begin
            if (etb(r * 14) >= mhz) begin
                return r;
            end
        end
        return 5;
    endfunction
    function automatic logic bad(input int r, input int k);
        return r > 4 || k > 5 || etb(r * 14 + 2 + 2 * k) == 8'hff || etb(r * 14 + 3 + 2 * k) == 8'hff;
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("counts: compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one host read; refused reads keep the previous data
    task automatic rd(input int k, input int a, input int mhz);
        int r;
        logic [7:0] last;
        logic [1:0] dc; // device code seen while the device drives data
        logic rj; // any device refusal seen during the frame
        r = bandof(mhz);
        last = data_o;
        dc = 2'h0;
        rj = 1'b0;
        @(posedge ref_clk_i);
        #1 kind_i = 3'(k);
        addr_i = 7'(a);
        freq_mhz_i = 8'(mhz);
        band_i = 3'(r);
        start_i = 1'b1;
        @(posedge ref_clk_i);
        #1 start_i = 1'b0;
        for (int i = 0; i < 600 && done_o !== 1'b1; i++) begin
            @(posedge ref_clk_i);
            #1;
            dc = (link1.miso_oe === 1'b1) ? dcode_o : dc;
            rj = rj | rej_o;
        end
        if (done_o !== 1'b1) begin
            failures++;
            end_sim();
        end
        chk(8'(unsup_o), 8'(bad(r, k)));
        chk(data_o, bad(r, k) ? last : etb(a));
        chk(8'(rj), 8'h00);
        if (!bad(r, k)) begin
            chk(8'(code_o), etb(r * 14 + 1));
            chk(8'(dc), etb(r * 14 + 1));
        end
    endtask

    // hand-driven frame on the second link with a 125 ns sck
    task automatic bb(input int r, input int k);
        int w;
        logic [9:0] cmd;
        w = bad(r, k) ? 10 : etb(r * 14 + 2 + 2 * k) + etb(r * 14 + 3 + 2 * k);
        cmd = {3'(k), 7'(r * 14 + 3 + 2 * k)};
        band2_i = 3'(r);
        #40 link2.cs_n = 1'b0;
        for (int n = 1; n <= 17 + w; n++) begin
            link2.mosi = (n <= 10) ? cmd[10 - n] : 1'b0;
            #62.5 link2.sck = 1'b1;
            #10;
            if (n >= 10 + w && !bad(r, k)) begin
                got[17 + w - n] = link2.miso;
            end
            chk(8'(link2.miso_oe), 8'(n >= 10 + w && !bad(r, k)));
            #52.5 link2.sck = 1'b0;
        end
        chk(8'(rej2_o), 8'(bad(r, k)));
        if (!bad(r, k)) begin
            chk(8'(dcode2_o), etb(r * 14 + 1));
            chk(got, etb(r * 14 + 3 + 2 * k));
        end
        #60 link2.cs_n = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        link2.sck = 1'b0;
        link2.cs_n = 1'b1;
        link2.mosi = 1'b0;
        repeat (20) @(posedge ref_clk_i);
        #1 rstn_i = 1'b1;
        chk(8'(link1.cs_n), 8'h01);
        chk(8'(busy_o), 8'h00);
        $display("test reset done");
        for (int a = 0; a < 70; a++) begin
            rd(bad(a / 14, a % 6) ? 1 : a % 6, a, etb((a / 14) * 14));
        end
        $display("test table walk done");
        for (int i = 0; i < 5; i++) begin
            rd(1, 1, 51 + (i == 1 ? 30 : i == 2 ? 40 : i == 3 ? 54 : i == 4 ? 83 : 0));
        end
        $display("test band edges done");
        rd(6, 0, 50);
        rd(1, 70, 50);
        rd(0, 5, 81);
        rd(4, 5, 105);
        $display("test refusals done");
        for (int r = 0; r < 6; r++) begin
            for (int k = 0; k < 7; k++) begin
                bb(r, k);
            end
        end
        $display("test device link done");
        end_sim();
    end

    // overall limit on the run
    initial begin
        #400000;
        failures++;
        end_sim();
    end
endmodule
